// ### core/cra_pkg.sv
// Overview of operation
// [RULE_01] Program counter holds 16-bit fetch address, increments after address output.
// [RULE_02] Jump, call or return load overrides the program counter increment.
// [RULE_03] Stack pointer addresses external stack top, decrements before each push.
// [RULE_04] Stack pointer increments after each popped byte.
// [RULE_05] Two independent 16-bit index bases, either selectable for indexing.
// [RULE_06] Indexed address is selected base plus signed displacement byte.
// [RULE_07] Vector table pointer is vector page high, peripheral byte low.
// [RULE_08] Peripheral supplies even low byte, least significant bit zero.
// [RULE_09] Read routine low byte at even pointer, high next, then call.
// [RULE_10] Refresh counter increments after every opcode fetch. A refresh load in the same cycle takes priority and skips the increment.
// [RULE_11] Refresh counter drives low address with strobe, adding no cycles.
// [RULE_12] Instructions can read and load the refresh counter.
// [RULE_13] Six dedicated registers: two 8-bit, four 16-bit.
// [RULE_14] Sixteen 8-bit working registers, main set duplicated in alternate.
// [RULE_15] Only one working set visible; the other keeps its contents.
// [RULE_16] Accumulator-flags swap exchanges only accumulator and flags.
// [RULE_17] General swap exchanges six byte registers, not accumulator or flags.
// [RULE_18] Refresh phase: low lines refresh count, upper lines vector page.
// [RULE_19] Vectored mode issues one acknowledge strobe carrying the low byte.
// [RULE_20] Set exchanges toggle a bank selector within the instruction.
`default_nettype none
package cra_pkg;
  localparam logic [15:0] CRA_PC_RST = 16'h0000;
  localparam logic [15:0] CRA_SP_RST = 16'hFFFF;
  localparam logic [15:0] CRA_IDX_RST = 16'h0000;
  localparam logic [7:0] CRA_BYTE_RST = 8'h00;
  localparam logic [15:0] CRA_ONE16 = 16'h0001;
  localparam logic [7:0] CRA_ONE8 = 8'h01;
  localparam int CRA_NREG = 8;

  // Working register selector within the visible set
  typedef enum logic [2:0] {
    CRA_R_A, CRA_R_F, CRA_R_B, CRA_R_C,
    CRA_R_D, CRA_R_E, CRA_R_H, CRA_R_L
  } cra_reg_t;

  // Program counter update source
  typedef enum logic [1:0] {
    CRA_PC_HOLD, CRA_PC_INC, CRA_PC_LOAD
  } cra_pcop_t;

  // Stack pointer update
  typedef enum logic [1:0] {
    CRA_SP_HOLD, CRA_SP_PUSH, CRA_SP_POP, CRA_SP_LOAD
  } cra_spop_t;

  // Dedicated register write target
  typedef enum logic [2:0] {
    CRA_W_NONE, CRA_W_IDX1, CRA_W_IDX2, CRA_W_VPAGE, CRA_W_REFR
  } cra_ded_t;
endpackage
`default_nettype wire

// ### core/cra_bank_if.sv
`default_nettype none
interface cra_bank_if;
  logic swap_accum_flags;
  logic swap_general_bank;
  logic accum_bank;
  logic general_bank;
  modport ctrl (output swap_accum_flags, output swap_general_bank,
    input accum_bank, input general_bank);
  modport sel (input swap_accum_flags, input swap_general_bank,
    output accum_bank, output general_bank);
endinterface
`default_nettype wire

// ### core/cra_bank_sel.sv
`default_nettype none
module cra_bank_sel
  import cra_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  cra_bank_if.sel bank
);
  typedef struct packed {
    logic accum;
    logic general;
  } cra_bank_st_t;

  cra_bank_st_t st_q;
  cra_bank_st_t st_d;

  // Swapping by selector toggle costs no data move and cannot lose bytes
  always_comb
  begin
    st_d = st_q;
    if (bank.swap_accum_flags)
    begin
      st_d.accum = ~st_q.accum; // [RULE_16] [RULE_20]
    end
    if (bank.swap_general_bank)
    begin
      st_d.general = ~st_q.general; // [RULE_17] [RULE_20]
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign bank.accum_bank = st_q.accum;
  assign bank.general_bank = st_q.general;
endmodule
`default_nettype wire

// ### core/cra_array.sv
`default_nettype none
module cra_array
  import cra_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  // Program counter control
  input wire cra_pcop_t pc_op,
  input wire logic [15:0] pc_target,
  // Stack pointer control
  input wire cra_spop_t sp_op,
  input wire logic [15:0] sp_load_value,
  // Dedicated register writes
  input wire cra_ded_t ded_wr_sel,
  input wire logic [15:0] ded_wr_data,
  // Indexed addressing
  input wire logic index_select,
  input wire logic [7:0] displacement,
  // Working register port
  input wire logic work_wr_en,
  input wire cra_reg_t work_wr_sel,
  input wire logic [7:0] work_wr_data,
  input wire cra_reg_t work_rd_sel,
  input wire logic swap_accum_flags,
  input wire logic swap_general_bank,
  // Opcode fetch and refresh
  input wire logic opcode_fetch_done,
  input wire logic refresh_phase,
  // Vectored interrupt
  input wire logic vector_ack_start,
  input wire logic [7:0] bus_data_in,
  input wire logic mem_rd_valid,
  output var logic irq_acknowledge_n,
  output var logic vector_call,
  output var logic [15:0] vector_target,
  output var logic [15:0] vector_read_addr,
  output var logic vector_read_req,
  output var logic refresh_strobe_n,
  output var logic [15:0] refresh_addr,
  output var logic [15:0] program_counter,
  output var logic [15:0] stack_pointer,
  output var logic [15:0] index_base_first,
  output var logic [15:0] index_base_second,
  output var logic [7:0] vector_page,
  output var logic [7:0] refresh_count,
  output var logic [15:0] indexed_addr,
  output var logic [7:0] work_rd_data
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    CRA_V_IDLE, CRA_V_ACK, CRA_V_LOW, CRA_V_HIGH
  } cra_vstate_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] idx1;
    logic [15:0] idx2;
    logic [7:0] vpage;
    logic [7:0] refr;
    cra_vstate_t vst;
    logic [15:0] vptr;
    logic [7:0] vlow;
    logic [15:0] vtarget;
    logic vcall;
    logic [7:0] rd;
  } cra_st_t;

  cra_st_t st_q;
  cra_st_t st_d;

  // Two banks of eight bytes; selector picks which bank is live
  logic [7:0] work_q [2][CRA_NREG];

  cra_bank_if bank_if ();

  cra_bank_sel u_bank (
    .clk(clk),
    .reset_n(reset_n),
    .bank(bank_if)
  );

  assign bank_if.swap_accum_flags = swap_accum_flags;
  assign bank_if.swap_general_bank = swap_general_bank;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic bank_of(input cra_reg_t r, input logic ab,
    input logic gb);
    begin
      bank_of = (r == CRA_R_A || r == CRA_R_F) ? ab : gb;
    end
  endfunction

  function automatic logic [15:0] sext_add(input logic [15:0] base,
    input logic [7:0] disp);
    begin
      sext_add = base + {{8{disp[7]}}, disp};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_d = st_q;
    st_d.vcall = 1'b0;
    // A taken jump wins over the post-fetch increment
    case (pc_op)
      CRA_PC_LOAD: st_d.pc = pc_target; // [RULE_02]
      CRA_PC_INC: st_d.pc = st_q.pc + CRA_ONE16; // [RULE_01]
      default: st_d.pc = st_q.pc;
    endcase
    case (sp_op)
      CRA_SP_PUSH: st_d.sp = st_q.sp - CRA_ONE16; // [RULE_03]
      CRA_SP_POP: st_d.sp = st_q.sp + CRA_ONE16; // [RULE_04]
      CRA_SP_LOAD: st_d.sp = sp_load_value;
      default: st_d.sp = st_q.sp;
    endcase
    case (ded_wr_sel)
      CRA_W_IDX1: st_d.idx1 = ded_wr_data; // [RULE_05]
      CRA_W_IDX2: st_d.idx2 = ded_wr_data; // [RULE_05]
      CRA_W_VPAGE: st_d.vpage = ded_wr_data[7:0];
      default: st_d.vpage = st_q.vpage;
    endcase
    // Program load of the counter beats the fetch increment
    if (ded_wr_sel == CRA_W_REFR)
    begin
      st_d.refr = ded_wr_data[7:0]; // [RULE_12]
    end
    else if (opcode_fetch_done)
    begin
      st_d.refr = st_q.refr + CRA_ONE8; // [RULE_10]
    end
    st_d.rd = work_q[bank_of(work_rd_sel, bank_if.accum_bank,
      bank_if.general_bank)][work_rd_sel]; // [RULE_15]
    case (st_q.vst)
      CRA_V_IDLE:
      begin
        if (vector_ack_start)
        begin
          st_d.vst = CRA_V_ACK;
        end
      end
      CRA_V_ACK:
      begin
        // Low bit forced clear; peripheral is expected to send it even
        st_d.vptr = {st_q.vpage, bus_data_in[7:1], 1'b0}; // [RULE_07] [RULE_08]
        st_d.vst = CRA_V_LOW; // [RULE_19]
      end
      CRA_V_LOW:
      begin
        if (mem_rd_valid)
        begin
          st_d.vlow = bus_data_in; // [RULE_09]
          st_d.vst = CRA_V_HIGH;
        end
      end
      CRA_V_HIGH:
      begin
        if (mem_rd_valid)
        begin
          st_d.vtarget = {bus_data_in, st_q.vlow}; // [RULE_09]
          st_d.vcall = 1'b1;
          st_d.vst = CRA_V_IDLE;
        end
      end
      default: st_d.vst = CRA_V_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_q.pc <= CRA_PC_RST;
      st_q.sp <= CRA_SP_RST;
      st_q.idx1 <= CRA_IDX_RST;
      st_q.idx2 <= CRA_IDX_RST;
      st_q.vpage <= CRA_BYTE_RST;
      st_q.refr <= CRA_BYTE_RST;
      st_q.vst <= CRA_V_IDLE;
      st_q.vptr <= CRA_IDX_RST;
      st_q.vlow <= CRA_BYTE_RST;
      st_q.vtarget <= CRA_IDX_RST;
      st_q.vcall <= 1'b0;
      st_q.rd <= CRA_BYTE_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Register contents are not cleared by reset, only control state
  always_ff @(posedge clk)
  begin
    if (work_wr_en)
    begin
      work_q[bank_of(work_wr_sel, bank_if.accum_bank,
        bank_if.general_bank)][work_wr_sel] <= work_wr_data; // [RULE_14] [RULE_15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign program_counter = st_q.pc; // [RULE_13]
  assign stack_pointer = st_q.sp;
  assign index_base_first = st_q.idx1;
  assign index_base_second = st_q.idx2;
  assign vector_page = st_q.vpage;
  assign refresh_count = st_q.refr;
  assign indexed_addr = sext_add(index_select ? st_q.idx2 : st_q.idx1,
    displacement); // [RULE_05] [RULE_06]
  assign work_rd_data = st_q.rd;
  // Strobe rides inside the fetch so refresh never stretches execution
  assign refresh_strobe_n = ~refresh_phase; // [RULE_11]
  assign refresh_addr = {st_q.vpage, st_q.refr}; // [RULE_18]
  assign irq_acknowledge_n = (st_q.vst != CRA_V_ACK); // [RULE_19]
  assign vector_read_req = (st_q.vst == CRA_V_LOW) ||
    (st_q.vst == CRA_V_HIGH);
  assign vector_read_addr = (st_q.vst == CRA_V_HIGH) ?
    (st_q.vptr | CRA_ONE16) : st_q.vptr; // [RULE_09]
  assign vector_call = st_q.vcall;
  assign vector_target = st_q.vtarget;
endmodule
`default_nettype wire

// ### verif/cra_array_checker.sv
`default_nettype none
module cra_array_checker
  import cra_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire cra_pcop_t pc_op,
  input wire logic [15:0] pc_target,
  input wire cra_spop_t sp_op,
  input wire cra_ded_t ded_wr_sel,
  input wire logic opcode_fetch_done,
  input wire logic refresh_phase,
  input wire logic irq_acknowledge_n,
  input wire logic vector_call,
  input wire logic refresh_strobe_n,
  input wire logic [15:0] refresh_addr,
  input wire logic [15:0] program_counter,
  input wire logic [15:0] stack_pointer,
  input wire logic [7:0] vector_page,
  input wire logic [7:0] refresh_count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  a_pc_step: assert property (pc_op == CRA_PC_INC |=>
    program_counter == $past(program_counter) + 16'h0001)
    else $error("pc step");
  a_pc_load: assert property (pc_op == CRA_PC_LOAD |=>
    program_counter == $past(pc_target))
    else $error("pc load");
  a_sp_push: assert property (sp_op == CRA_SP_PUSH |=>
    stack_pointer == $past(stack_pointer) - 16'h0001)
    else $error("sp push");
  a_sp_pop: assert property (sp_op == CRA_SP_POP |=>
    stack_pointer == $past(stack_pointer) + 16'h0001)
    else $error("sp pop");
  a_refresh_tick: assert property (
    opcode_fetch_done && ded_wr_sel != CRA_W_REFR |=>
    refresh_count == $past(refresh_count) + 8'h01) else $error("r tick");
  a_refresh_bus: assert property (
    refresh_strobe_n == !refresh_phase &&
    refresh_addr == {vector_page, refresh_count}) else $error("r bus");
  a_ack_single: assert property (
    !irq_acknowledge_n |=> irq_acknowledge_n) else $error("ack");
  a_call_pulse: assert property (
    vector_call |=> !vector_call) else $error("call");
  c_call: cover property (vector_call);
  c_push_pop: cover property (sp_op == CRA_SP_PUSH ##1 sp_op == CRA_SP_POP);
  c_r_load: cover property (opcode_fetch_done && ded_wr_sel == CRA_W_REFR);
endmodule
`default_nettype wire

// ### verif/cra_mem_model.sv
`default_nettype none
module cra_mem_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] lat,
  input wire logic [7:0] vec,
  input wire logic irq_acknowledge_n,
  input wire logic vector_read_req,
  input wire logic [15:0] vector_read_addr,
  output logic [7:0] bus_data_in,
  output logic mem_rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_q;
  logic [7:0] last_q;
  ////////////////////////////////////////
  assign mem_rd_valid = vector_read_req && wait_q == lat;
  always_comb
  begin
    if (!irq_acknowledge_n)
      bus_data_in = {vec[7:1], 1'b0};
    else if (mem_rd_valid)
      bus_data_in = vector_read_addr[7:0] ^ vector_read_addr[15:8] ^ 8'h5A;
    else
      bus_data_in = ~last_q;
  end
  // Released bus toggles so a stale byte is never taken as data
  always_ff @(posedge clk)
  begin
    last_q <= reset_n ? bus_data_in : 8'hA5;
    wait_q <= (!reset_n || !vector_read_req || mem_rd_valid) ? 2'h0 :
      wait_q + 2'h1;
  end
endmodule
`default_nettype wire

// ### verif/cra_array_tb.sv
`default_nettype none
module cra_array_tb
  import cra_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, index_select, work_wr_en, swap_accum_flags;
  logic swap_general_bank, opcode_fetch_done, refresh_phase;
  logic vector_ack_start, mem_rd_valid, irq_acknowledge_n, vector_call;
  logic vector_read_req, refresh_strobe_n;
  logic [15:0] pc_target, sp_load_value, ded_wr_data, vector_target;
  logic [15:0] vector_read_addr, refresh_addr, program_counter;
  logic [15:0] stack_pointer, index_base_first, index_base_second;
  logic [15:0] indexed_addr, m_pc, m_sp, m_ix, m_iy;
  logic [7:0] displacement, work_wr_data, bus_data_in, vector_page;
  logic [7:0] refresh_count, work_rd_data, vec, m_vp, m_r, m_w [16];
  logic [1:0] lat;
  logic m_ab, m_gb, filled;
  cra_pcop_t pc_op;
  cra_spop_t sp_op;
  cra_ded_t ded_wr_sel;
  cra_reg_t work_wr_sel, work_rd_sel;
  int num_errors, tests_run;
  cra_array u_cra_array (.*);
  cra_mem_model u_cra_mem_model (.*);
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk16({8'h00, got}, {8'h00, exp});
  endtask
  task automatic hold();
    pc_op = CRA_PC_HOLD;
    sp_op = CRA_SP_HOLD;
    ded_wr_sel = CRA_W_NONE;
    {work_wr_en, swap_accum_flags, swap_general_bank} = 3'h0;
  endtask
  task automatic rnd();
    pc_op = cra_pcop_t'($urandom_range(2));
    sp_op = cra_spop_t'($urandom_range(3));
    ded_wr_sel = cra_ded_t'($urandom_range(4));
    work_wr_sel = cra_reg_t'($urandom_range(7));
    work_rd_sel = cra_reg_t'($urandom_range(7));
    {pc_target, sp_load_value} = $urandom;
    {ded_wr_data, displacement, work_wr_data} = $urandom;
    {index_select, work_wr_en, opcode_fetch_done, refresh_phase} =
      4'($urandom);
    swap_accum_flags = $urandom_range(3) == 0;
    swap_general_bank = $urandom_range(3) == 0;
  endtask
  function automatic logic [3:0] wi(input cra_reg_t s);
    return {s < CRA_R_B ? m_ab : m_gb, s};
  endfunction
  task automatic step();
    logic [7:0] rd;
    logic ok;
    @(posedge clk);
    rd = m_w[wi(work_rd_sel)];
    // Same-edge write on the read register, or any swap, is left open
    ok = filled && !swap_accum_flags && !swap_general_bank &&
      !(work_wr_en && work_wr_sel == work_rd_sel);
    m_pc = pc_op == CRA_PC_LOAD ? pc_target :
      m_pc + 16'(pc_op == CRA_PC_INC);
    m_sp = sp_op == CRA_SP_LOAD ? sp_load_value :
      m_sp + 16'(sp_op == CRA_SP_POP) - 16'(sp_op == CRA_SP_PUSH);
    m_ix = ded_wr_sel == CRA_W_IDX1 ? ded_wr_data : m_ix;
    m_iy = ded_wr_sel == CRA_W_IDX2 ? ded_wr_data : m_iy;
    m_vp = ded_wr_sel == CRA_W_VPAGE ? ded_wr_data[7:0] : m_vp;
    m_r = ded_wr_sel == CRA_W_REFR ? ded_wr_data[7:0] :
      m_r + 8'(opcode_fetch_done);
    if (work_wr_en)
      m_w[wi(work_wr_sel)] = work_wr_data;
    m_ab ^= swap_accum_flags;
    m_gb ^= swap_general_bank;
    #1;
    chk16(program_counter, m_pc);
    chk16(stack_pointer, m_sp);
    chk16(index_base_first, m_ix);
    chk16(index_base_second, m_iy);
    chk8(vector_page, m_vp);
    chk8(refresh_count, m_r);
    chk16(refresh_addr, {m_vp, m_r});
    chk8({7'h00, refresh_strobe_n}, {7'h00, !refresh_phase});
    chk16(indexed_addr, (index_select ? m_iy : m_ix) +
      {{8{displacement[7]}}, displacement});
    if (ok)
      chk8(work_rd_data, rd);
  endtask
  task automatic vect(input logic [1:0] l);
    logic [7:0] lo;
    int n;
    int acks;
    lat = l;
    vec = 8'($urandom);
    lo = {vec[7:1], 1'b0} ^ m_vp ^ 8'h5A;
    hold();
    vector_ack_start = 1'b1;
    step();
    vector_ack_start = 1'b0;
    {n, acks} = '0;
    while (vector_call !== 1'b1 && n < 20)
    begin
      acks += int'(irq_acknowledge_n === 1'b0);
      rnd();
      ded_wr_sel = CRA_W_NONE;
      step();
      n++;
    end
    if (n == 20)
    begin
      num_errors++;
      $display("unexpected %0t: no call", $time);
      end_of_test();
    end
    chk16(vector_target, {lo ^ 8'h01, lo});
    chk8(8'(acks), 8'h01);
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'h734587e8));
    {num_errors, tests_run, filled, lat, vec} = '0;
    rnd();
    hold();
    {vector_ack_start, reset_n, m_ab, m_gb} = 4'h0;
    {m_pc, m_sp, m_ix, m_iy} = {CRA_PC_RST, CRA_SP_RST, CRA_IDX_RST,
      CRA_IDX_RST};
    {m_vp, m_r} = {CRA_BYTE_RST, CRA_BYTE_RST};
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    step();
    for (int i = 0; i < 16; i++)
    begin
      work_wr_en = 1'b1;
      work_wr_sel = cra_reg_t'(i % 8);
      work_wr_data = 8'($urandom);
      {swap_accum_flags, swap_general_bank} = {2{i == 7}};
      step();
    end
    filled = 1'b1;
    repeat (400)
    begin
      rnd();
      step();
    end
    vect(2'h0);
    vect(2'h2);
    end_of_test();
  end
endmodule
bind cra_array cra_array_checker u_cra_array_checker (.*);
`default_nettype wire
